// File: logic/sarc_pkg.sv
// Purpose: Shared constants and types of the SAR conversion control block
// Assumes: 250 MHz system clock, synchronous active-high reset
// Notes:   Times are given in ns and turned into clock counts here
package sarc_pkg;

  localparam int RES_BITS = 16;
  localparam int CFG_BITS = 14;
  localparam int OUT_BITS = RES_BITS + CFG_BITS;
  localparam int IDX_W    = 4;
  localparam int DIN_CNT_W = 4;

  localparam int CLK_PERIOD_NS = 4;

  // Switches must be open before the arrays move to ground
  localparam int SW_OPEN_NS  = 8;
  localparam int SW_OPEN_CYC =
    (SW_OPEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPEN_CNT_W  = 4;

  // One bit trial of the internal conversion clock
  localparam int TRIAL_NS  = 100;
  localparam int TRIAL_CYC =
    (TRIAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Highest conversion rate, as the shortest start-to-start spacing
  localparam int MAX_RATE_KSPS = 250;
  localparam int MIN_CYCLE_NS  = 1000000 / MAX_RATE_KSPS;
  localparam int MIN_CYCLE_CYC = MIN_CYCLE_NS / CLK_PERIOD_NS;
  localparam int RATE_CNT_W    = 10;

  localparam logic [RES_BITS-1:0] MSB_MASK    = 16'h8000;
  localparam logic [RES_BITS-1:0] CODE_RESET  = 16'h0000;
  localparam logic [CFG_BITS-1:0] CFG_RESET   = 14'h3fff;
  localparam logic                SW_CLOSED   = 1'b1;

  typedef enum logic [1:0] {
    ST_ACQ,
    ST_OPEN,
    ST_TRIAL,
    ST_CODE
  } sarc_state_e;

  // Configuration word, first bit shifted in at the top
  typedef struct packed {
    logic       overwrite;
    logic [2:0] input_mode;
    logic [2:0] channel;
    logic       full_bw;
    logic [2:0] reference;
    logic [1:0] sequencer;
    logic       readback_n;
  } sarc_cfg_s;

  // Controls toward the analog core
  typedef struct packed {
    logic                sample_switch_pos;
    logic                sample_switch_neg;
    logic                array_input_connect;
    logic                converter_power_en;
    logic [RES_BITS-1:0] trial_code;
  } sarc_analog_s;

endpackage

// File: logic/sarc_sync2.sv
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Each bit is an independent level
// Notes:   Only q leaves this module; the first stage stays private
module sarc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// File: logic/sarc_tick.sv
// Purpose: Divider giving a one-cycle enable every PERIOD clocks
// Assumes: clear restarts the period so the first tick is a full one
// Notes:   Used as the internal conversion clock
module sarc_tick #(
  parameter int PERIOD = 25,
  parameter int CNT_W  = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clear,
  output logic      tick
);

  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r == CNT_W'(PERIOD - 1)) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
      tick  <= 1'b0;
    end
  end

endmodule

// File: logic/sarc_top.sv
// Purpose: Control logic of a 16-bit successive-approximation converter
// Assumes: Pins and comparator are asynchronous and are synchronised here
// Notes:   Serial port is sampled, not clocked; serial clock is a plain pin
//
// Summary of operation
// - A rising edge on conversion_start ends acquisition and starts a conversion.
// - The sample switches open first, and only later are the arrays grounded.
// - Sixteen binary-weighted trials run from the MSB down to the LSB.
// - After the last trial acquisition resumes, then code and busy-low follow.
// - Trials are paced by an internal conversion clock, not the serial clock.
// - Unipolar inputs give straight binary codes.
// - Bipolar inputs give twos complement codes.
// - Over-range inputs give the top code without wrapping.
// - Under-range inputs give the bottom code.
// - A 14-bit configuration word is shifted in over the serial port.
// - The result can be read during or after conversion, with optional config.
// - The result read always belongs to the latest accepted conversion start.
// - Starts 1001 or more clocks apart are served and the converter sleeps in between.
// - With conversion_start low during conversion a busy level shows on data out.
// - Serial data moves MSB first on the host's serial clock.
module sarc_top
  import sarc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          conversion_start,
  input  wire logic          serial_clock,
  input  wire logic          serial_data_in,
  input  wire logic          comparator_keep,
  output sarc_analog_s       analog_ctrl,
  output logic [RES_BITS-1:0] result_code,
  output sarc_cfg_s          config_word,
  output logic               busy,
  output logic               serial_data_out,
  output logic               serial_data_out_en
);

  // Pin synchronisation and edge finding
  logic [3:0] pins_s;
  logic       cnv_s;
  logic       sck_s;
  logic       din_s;
  logic       keep_s;
  logic       cnv_d_r;
  logic       sck_d_r;
  logic       cnv_rise;
  logic       cnv_fall;
  logic       sck_rise;
  logic       sck_fall;

  sarc_sync2 #(
    .W (4)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({conversion_start, serial_clock, serial_data_in,
           comparator_keep}),
    .q   (pins_s)
  );
  assign {cnv_s, sck_s, din_s, keep_s} = pins_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnv_d_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      cnv_d_r <= cnv_s;
      sck_d_r <= sck_s;
    end
  end
  assign cnv_rise = cnv_s & ~cnv_d_r;
  assign cnv_fall = ~cnv_s & cnv_d_r;
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;

  // Conversion sequencing
  sarc_state_e          state_r;
  logic [OPEN_CNT_W-1:0] open_cnt_r;
  logic [IDX_W-1:0]     bit_idx_r;
  logic [RATE_CNT_W-1:0] since_start_r;
  logic                 rate_ok;
  logic                 start;
  logic                 open_done;
  logic                 trial_tick;
  logic                 last_trial;
  logic [RES_BITS-1:0]  trial_r;
  logic [RES_BITS-1:0]  trial_nxt;
  logic [RES_BITS-1:0]  cur_bit;
  sarc_cfg_s            cfg_r;
  sarc_cfg_s            conv_cfg_r;
  logic                 unipolar;
  logic [RES_BITS-1:0]  code_nxt;

  // Starts closer than the fastest rate allows are dropped
  assign rate_ok    = since_start_r == RATE_CNT_W'(MIN_CYCLE_CYC);
  assign start      = cnv_rise && (state_r == ST_ACQ) && rate_ok;
  assign open_done  = (state_r == ST_OPEN) &&
                      (open_cnt_r == OPEN_CNT_W'(SW_OPEN_CYC - 1));
  assign last_trial = (state_r == ST_TRIAL) && trial_tick &&
                      (bit_idx_r == '0);

  // Internal conversion clock, restarted as the trials begin
  sarc_tick #(
    .PERIOD (TRIAL_CYC),
    .CNT_W  (8)
  ) u_conv_clk (
    .clk   (clk),
    .rst   (rst),
    .clear (state_r != ST_TRIAL),
    .tick  (trial_tick)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      since_start_r <= RATE_CNT_W'(MIN_CYCLE_CYC);
    end else if (start) begin
      since_start_r <= '0;
    end else if (!rate_ok) begin
      since_start_r <= since_start_r + RATE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_ACQ;
    end else begin
      case (state_r)
        ST_ACQ: begin
          if (start) begin
            state_r <= ST_OPEN;
          end
        end
        ST_OPEN: begin
          if (open_done) begin
            state_r <= ST_TRIAL;
          end
        end
        ST_TRIAL: begin
          if (last_trial) begin
            state_r <= ST_CODE;
          end
        end
        ST_CODE: begin
          state_r <= ST_ACQ;
        end
        default: begin
          state_r <= ST_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_r != ST_OPEN) begin
      open_cnt_r <= '0;
    end else begin
      open_cnt_r <= open_cnt_r + OPEN_CNT_W'(1);
    end
  end

  // Decide the bit under trial, then try the next lower one
  assign cur_bit = RES_BITS'(1) << bit_idx_r;
  always_comb begin
    trial_nxt = trial_r;
    if (!keep_s) begin
      trial_nxt = trial_nxt & ~cur_bit;
    end
    if (bit_idx_r != '0) begin
      trial_nxt = trial_nxt | (cur_bit >> 1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_idx_r <= '0;
    end else if (open_done) begin
      bit_idx_r <= IDX_W'(RES_BITS - 1);
    end else if (trial_tick && state_r == ST_TRIAL && bit_idx_r != '0) begin
      bit_idx_r <= bit_idx_r - IDX_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trial_r <= CODE_RESET;
    end else if (open_done) begin
      trial_r <= MSB_MASK;
    end else if (trial_tick && state_r == ST_TRIAL) begin
      trial_r <= trial_nxt;
    end
  end

  // Switch and power sequencing toward the analog core
  logic sw_pos_r, sw_neg_r, arr_conn_r, pwr_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_pos_r   <= SW_CLOSED;
      sw_neg_r   <= SW_CLOSED;
      arr_conn_r <= 1'b1;
      pwr_r      <= 1'b0;
    end else if (start) begin
      sw_pos_r   <= ~SW_CLOSED;
      sw_neg_r   <= ~SW_CLOSED;
      pwr_r      <= 1'b1;
    end else if (open_done) begin
      arr_conn_r <= 1'b0;
    end else if (last_trial) begin
      sw_pos_r   <= SW_CLOSED;
      sw_neg_r   <= SW_CLOSED;
      arr_conn_r <= 1'b1;
      pwr_r      <= 1'b0;
    end
  end
  assign analog_ctrl = {sw_pos_r, sw_neg_r, arr_conn_r, pwr_r, trial_r};

  // Saturation falls out of the search: all keeps give all ones and
  // no keeps give zero, so flipping the MSB never wraps in bipolar
  assign unipolar = conv_cfg_r.input_mode[2];
  assign code_nxt = unipolar ? trial_r : (trial_r ^ MSB_MASK);

  always_ff @(posedge clk) begin
    if (rst) begin
      result_code <= CODE_RESET;
    end else if (state_r == ST_CODE) begin
      result_code <= code_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (state_r == ST_CODE) begin
      busy <= 1'b0;
    end
  end

  // Configuration input
  logic [DIN_CNT_W-1:0] din_cnt_r;
  logic [CFG_BITS-1:0]  din_sh_r;
  logic [CFG_BITS-1:0]  din_word;
  logic                 din_take;

  assign din_take = ~cnv_s && sck_rise &&
                    (din_cnt_r < DIN_CNT_W'(CFG_BITS));
  assign din_word = {din_sh_r[CFG_BITS-2:0], din_s};

  always_ff @(posedge clk) begin
    if (rst || cnv_fall) begin
      din_cnt_r <= '0;
      din_sh_r  <= '0;
    end else if (din_take) begin
      din_cnt_r <= din_cnt_r + DIN_CNT_W'(1);
      din_sh_r  <= din_word;
    end
  end

  // Word only takes effect when its top bit asks to overwrite
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= sarc_cfg_s'(CFG_RESET);
    end else if (din_take && din_cnt_r == DIN_CNT_W'(CFG_BITS - 1) &&
                 din_word[CFG_BITS-1]) begin
      cfg_r <= sarc_cfg_s'(din_word);
    end
  end
  assign config_word = cfg_r;

  // Settings in force for the conversion now running
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_cfg_r <= sarc_cfg_s'(CFG_RESET);
    end else if (start) begin
      conv_cfg_r <= cfg_r;
    end
  end

  // Result output
  logic [OUT_BITS-1:0] out_sh_r;
  logic [OUT_BITS-1:0] out_load;
  logic [OUT_BITS-1:0] out_done;
  logic                lead_r;
  logic                busy_mode_r;
  logic                sdo_nxt;
  assign out_load = {result_code, conv_cfg_r.readback_n ?
                     CFG_BITS'(0) : CFG_BITS'(conv_cfg_r)};
  assign out_done = {code_nxt, conv_cfg_r.readback_n ?
                     CFG_BITS'(0) : CFG_BITS'(conv_cfg_r)};
  // Host held start low while converting: show busy on data out
  always_ff @(posedge clk) begin
    if (rst || start) begin
      busy_mode_r <= 1'b0;
    end else if (~cnv_s && state_r != ST_ACQ) begin
      busy_mode_r <= 1'b1;
    end
  end

  // A read begun before completion is reloaded with the new result at completion
  always_ff @(posedge clk) begin
    if (rst) begin
      out_sh_r <= '0;
      lead_r   <= 1'b0;
    end else if (state_r == ST_CODE) begin
      out_sh_r <= out_done;
      lead_r   <= busy_mode_r;
    end else if (cnv_fall && state_r == ST_ACQ) begin
      out_sh_r <= out_load;
      lead_r   <= 1'b0;
    end else if (~cnv_s && sck_fall && !(busy && busy_mode_r)) begin
      if (lead_r) begin
        lead_r <= 1'b0;
      end else begin
        out_sh_r <= {out_sh_r[OUT_BITS-2:0], 1'b0};
      end
    end
  end

  always_comb begin
    if (busy && busy_mode_r) begin
      sdo_nxt = 1'b1;
    end else if (lead_r) begin
      sdo_nxt = 1'b0;
    end else begin
      sdo_nxt = out_sh_r[OUT_BITS-1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      serial_data_out    <= 1'b0;
      serial_data_out_en <= 1'b0;
    end else begin
      serial_data_out    <= sdo_nxt;
      serial_data_out_en <= ~cnv_s;
    end
  end

endmodule

// File: test/sarc_top_chk.sv
// Purpose: Port-level checks of the SAR conversion control block
// Assumes: Pins move a little after the clock edge
// Notes:   Bound to sarc_top from the bench top file
module sarc_top_chk
  import sarc_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          conversion_start,
  input wire logic          serial_clock,
  input wire logic          serial_data_in,
  input wire logic          comparator_keep,
  input sarc_analog_s       analog_ctrl,
  input wire logic [RES_BITS-1:0] result_code,
  input sarc_cfg_s          config_word,
  input wire logic          busy,
  input wire logic          serial_data_out,
  input wire logic          serial_data_out_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        sw_p, sw_n, arr_in, pwr;
  logic [15:0] trial;
  logic [10:0] gap_r;
  logic [10:0] len_r;
  assign sw_p   = analog_ctrl.sample_switch_pos;
  assign sw_n   = analog_ctrl.sample_switch_neg;
  assign arr_in = analog_ctrl.array_input_connect;
  assign pwr    = analog_ctrl.converter_power_en;
  assign trial  = analog_ctrl.trial_code;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Saturates so the first start after reset is never judged too early
  always_ff @(posedge clk) begin
    if (rst) gap_r <= 11'h7ff;
    else if ($rose(busy)) gap_r <= 11'h000;
    else if (gap_r != 11'h7ff) gap_r <= gap_r + 11'h001;
  end
  always_ff @(posedge clk) begin
    if (rst || $rose(busy)) len_r <= 11'h000;
    else if (busy) len_r <= len_r + 11'h001;
  end

  open_first_a: assert property ($rose(busy) |->
    !sw_p && !sw_n && arr_in && pwr) else $error("start did not open");
  ground_late_a: assert property ($fell(sw_p) |->
    arr_in[*2] ##1 !arr_in) else $error("arrays grounded off time");
  ground_open_a: assert property (!arr_in |-> !sw_p && !sw_n)
    else $error("arrays grounded with switches shut");
  trial_step_a: assert property ($fell(arr_in) |-> (trial == 16'h8000)
    ##1 $stable(trial)[*8] ##[14:18] (trial[14:0] == 15'h4000))
    else $error("trial order or pace wrong");
  done_acq_a: assert property ($fell(busy) |->
    sw_p && sw_n && arr_in && !pwr) else $error("no return to acquire");
  conv_len_a: assert property ($fell(busy) |->
    len_r >= 11'h190 && len_r <= 11'h19a) else $error("busy length");
  power_a: assert property (pwr |-> busy)
    else $error("converter powered while idle");
  rate_a: assert property ($rose(busy) |-> gap_r >= 11'h3e7)
    else $error("start accepted too soon");
  code_hold_a: assert property ($changed(result_code) |-> $past(busy))
    else $error("code moved outside a conversion");
  busy_sdo_a: assert property (busy && $past(busy, 3) && serial_data_out_en
    && $past(serial_data_out_en, 2) |-> serial_data_out)
    else $error("busy level missing on data out");
  sdo_en_a: assert property ($fell(conversion_start) |->
    ##[2:4] serial_data_out_en) else $error("data out not enabled");

  cover property ($fell(busy) && result_code == 16'h7fff);
  cover property ($rose(busy) && gap_r < 11'h7ff);
  cover property (busy && serial_data_out_en && serial_data_out);
endmodule

// File: test/sarc_host_bfm.sv
// Purpose: Host controller and ideal comparator facing the SAR control
// Assumes: 4 ns bench clock; serial clock of 32 ns made here
// Notes:   Serial clock stands low outside frames
module sarc_host_bfm
  import sarc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [RES_BITS-1:0] trial,
  input  wire logic                serial_data_out,
  output logic                     conversion_start,
  output logic                     serial_clock,
  output logic                     serial_data_in,
  output logic                     comparator_keep
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [RES_BITS-1:0] target;

  // Keep the bit while the trial is not above the held input
  assign comparator_keep = (trial <= target);
  initial begin
    conversion_start = 1'b0;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
    target = 16'h0000;
  end

  task automatic start();
    @(posedge clk) #1 conversion_start = 1'b1;
  endtask
  task automatic lower();
    @(posedge clk) #1 conversion_start = 1'b0;
  endtask

  // Config rides on the first bits; unused input bits keep toggling
  task automatic frame(input logic [CFG_BITS-1:0] cfg,
                       output logic [OUT_BITS-1:0] rd);
    lower();
    for (int i = OUT_BITS - 1; i >= 0; i--) begin
      serial_data_in = (i >= RES_BITS) ? cfg[i-RES_BITS] : ~serial_data_in;
      repeat (4) @(posedge clk);
      #1 serial_clock = 1'b1;
      repeat (4) @(posedge clk);
      #1 rd[i] = serial_data_out;
      serial_clock = 1'b0;
    end
  endtask
endmodule

// File: test/tb.sv
// Purpose: Self-checking bench of the SAR conversion control block
// Assumes: Host stand-in drives every pin of the block but clk and rst
// Notes:   Each scenario judges its own results before returning
module tb
  import sarc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [13:0] BIP = 14'h29c8;
  localparam logic [13:0] UNI = 14'h3ea0;
  logic                clk, rst, conversion_start, serial_clock;
  logic                serial_data_in, comparator_keep, busy;
  logic                serial_data_out, serial_data_out_en;
  sarc_analog_s        analog_ctrl;
  sarc_cfg_s           config_word;
  logic [RES_BITS-1:0] result_code;
  int                  err_count, compares;

  sarc_top sarc_top_i (.clk(clk), .rst(rst),
    .conversion_start(conversion_start), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .comparator_keep(comparator_keep),
    .analog_ctrl(analog_ctrl), .result_code(result_code),
    .config_word(config_word), .busy(busy),
    .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en));
  sarc_host_bfm sarc_host_bfm_i (.clk(clk), .trial(analog_ctrl.trial_code),
    .serial_data_out(serial_data_out), .conversion_start(conversion_start),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .comparator_keep(comparator_keep));

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk) #1 n++;
    end
    check(16'(busy), 16'(lvl), "busy level");
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Gap before each start keeps start spacing above the rate limit
  task automatic convert_read(input logic [15:0] tgt, input logic [13:0] cfg,
                              input logic [15:0] code, input logic [13:0] rb);
    logic [OUT_BITS-1:0] rd;
    repeat (450) @(posedge clk);
    sarc_host_bfm_i.target = tgt;
    sarc_host_bfm_i.start();
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 600);
    check(result_code, code, "code");
    sarc_host_bfm_i.frame(cfg, rd);
    check(rd[29:14], code, "serial code");
    check(16'(rd[13:0]), 16'(rb), "readback");
  endtask
  task automatic t_reset();
    check(16'({analog_ctrl[19:16], busy, serial_data_out_en}), 16'h0038,
          "idle pins");
    check(16'(config_word), 16'h3fff, "config idle");
    check(result_code, 16'h0000, "code idle");
  endtask
  task automatic t_codes();
    convert_read(16'h0000, 14'h0000, 16'h0000, 14'h0000);
    check(16'(config_word), 16'h3fff, "config kept");
    convert_read(16'h8000, 14'h0000, 16'h8000, 14'h0000);
    convert_read(16'hffff, BIP, 16'hffff, 14'h0000);
    check(16'(config_word), 16'(BIP), "config");
    convert_read(16'hffff, BIP, 16'h7fff, BIP);
    convert_read(16'h8000, BIP, 16'h0000, BIP);
    convert_read(16'h0000, UNI, 16'h8000, BIP);
    convert_read(16'h1234, UNI, 16'h1234, UNI);
  endtask
  task automatic t_rate();
    logic [OUT_BITS-1:0] rd;
    repeat (450) @(posedge clk);
    sarc_host_bfm_i.start();
    wait_busy(1'b1, 20);
    wait_busy(1'b0, 600);
    sarc_host_bfm_i.frame(14'h0000, rd);
    sarc_host_bfm_i.start();
    repeat (20) @(posedge clk);
    check(16'(busy), 16'h0000, "fast start taken");
  endtask
  task automatic t_busy();
    repeat (1000) @(posedge clk);
    // Result MSB high, so a missing lead bit would show as a one
    sarc_host_bfm_i.target = 16'hffff;
    sarc_host_bfm_i.lower();
    repeat (8) @(posedge clk);
    sarc_host_bfm_i.start();
    wait_busy(1'b1, 20);
    repeat (20) @(posedge clk);
    sarc_host_bfm_i.lower();
    repeat (10) @(posedge clk);
    check(16'({serial_data_out_en, serial_data_out}), 16'h0003,
          "busy shown");
    wait_busy(1'b0, 600);
    repeat (8) @(posedge clk);
    check(16'(serial_data_out), 16'h0000, "lead bit");
    // Let the start spacing lapse before the next conversion
    repeat (300) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #120000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 t_reset();
    rst = 1'b0;
    t_codes();
    t_rate();
    t_busy();
    convert_read(16'h00ff, 14'h0000, 16'h00ff, UNI);
    conclude();
  end
endmodule

bind sarc_top sarc_top_chk sarc_top_chk_i (.clk(clk), .rst(rst),
  .conversion_start(conversion_start), .serial_clock(serial_clock),
  .serial_data_in(serial_data_in), .comparator_keep(comparator_keep),
  .analog_ctrl(analog_ctrl), .result_code(result_code),
  .config_word(config_word), .busy(busy),
  .serial_data_out(serial_data_out),
  .serial_data_out_en(serial_data_out_en));
